// file: rtl/socc_regs.vh
// What this block does
// - A driver of outputs 1 to 4 is enabled only while its feeding PLL is powered up.
// - Without PLL1 software enable, the low powerdown pin powers PLL1 down.
// - With PLL1 software enable set, the PLL1 bit alone sets its power.
// - PLL2 power follows its software bit only; host always sets its enable.
// - Without override, reading the enable register shows the filtered pin level.
// - Without override, the driver enable bit is read-only; writes are dropped.
// - With override set, the driver enable bit replaces the pin as the driver's enable.
// - Override bits load from programmed defaults at power-up.
// - Enabling holds steady dc about 2 us, then toggles without glitches.
// - Disabling stops toggling at dc first, then bias off and high impedance.
// - Two-bit format per output: LVCMOS, LVDS, LVPECL, HCSL; one write sets outputs 1 to 4.
// - Power-up format of every output is LVCMOS from programmed defaults.
// - LVCMOS drives the positive pin only; other formats drive both pins.
// - Programmed override with enable clear holds the output off from the second clock after reset release.
// - PLL1 uses reference 2 only when its select enable and select are both 1.
// - PLL2 uses reference 2 only when its select enable and select are both 1.
// - A crystal amplifier runs while any powered PLL or the enabled buffer output selects it.
// - Crystal force bits hold the matching amplifier on regardless of selection.
// - Either reference can feed the buffered output, with the four formats.
// - Buffered output enable bit overrides its pin when its override is set.
// - Soft reset acts only while its companion enable bit is 1.
// - After power-on reset release, all control registers load from programmed defaults.
`ifndef SOCC_REGS_VH
`define SOCC_REGS_VH
`define SOCC_ADDR_W 4
`define SOCC_REG_CTRL 4'h2
`define SOCC_REG_REFB 4'h3
`define SOCC_REG_FMT 4'h4
`define SOCC_B_PLL1_EN 0
`define SOCC_B_PLL1 1
`define SOCC_B_PLL2_EN 2
`define SOCC_B_PLL2 3
`define SOCC_B_RS1_EN 4
`define SOCC_B_RS1 5
`define SOCC_B_RS2_EN 6
`define SOCC_B_RS2 7
`define SOCC_B_OUT_BASE 8
`define SOCC_B_REFO_EN 16
`define SOCC_B_REFO 17
`define SOCC_B_SR_EN 18
`define SOCC_B_SR 19
`define SOCC_CTRL_W 24
`define SOCC_CTRL_RW_MASK 24'h0f55ff
`define SOCC_B_REFO_MUX 27
`define SOCC_B_XTAL1 26
`define SOCC_B_REFO_MODE 30
`define SOCC_B_XTAL2 15
`define SOCC_FMT_LVCMOS 2'h0
`define SOCC_SETTLE_NS 2000
`define SOCC_CLK_MHZ 250
`define SOCC_SETTLE_CYC ((`SOCC_SETTLE_NS * `SOCC_CLK_MHZ) / 1000)
`define SOCC_CNT_W 10
`define SOCC_ST_OFF 4'h1
`define SOCC_ST_SETTLE 4'h2
`define SOCC_ST_RUN 4'h4
`define SOCC_ST_STOP 4'h8
`endif

// file: rtl/socc_seq.v
`timescale 1ns/1ps
`include "socc_regs.vh"
module socc_seq (
    input wire clk_i,
    input wire rst_n_i,
    input wire en_i,
    input wire [1:0] fmt_i,
    output reg bias_o,
    output reg toggle_o,
    output wire drive_p_o,
    output wire drive_n_o
);
    localparam [3:0] ST_OFF = `SOCC_ST_OFF;
    localparam [3:0] ST_SETTLE = `SOCC_ST_SETTLE;
    localparam [3:0] ST_RUN = `SOCC_ST_RUN;
    localparam [3:0] ST_STOP = `SOCC_ST_STOP;
    localparam integer SETTLE_FULL = `SOCC_SETTLE_CYC - 1;
    localparam [`SOCC_CNT_W-1:0] SETTLE_LAST = SETTLE_FULL[`SOCC_CNT_W-1:0];
    reg [3:0] st_r;
    reg [3:0] st_nxt;
    reg [`SOCC_CNT_W-1:0] cnt_r;
    always @*
    begin
        st_nxt = st_r;
        case (st_r)
            ST_OFF: if (en_i) st_nxt = ST_SETTLE;
            ST_SETTLE:
            begin
                if (!en_i)
                    st_nxt = ST_OFF;
                else if (cnt_r == SETTLE_LAST)
                    st_nxt = ST_RUN;
            end
            ST_RUN: if (!en_i) st_nxt = ST_STOP;
            ST_STOP: st_nxt = ST_OFF;
            default: st_nxt = ST_OFF;
        endcase
    end
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= ST_OFF;
            cnt_r <= {`SOCC_CNT_W{1'b0}};
            bias_o <= 1'b0;
            toggle_o <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= (st_r == ST_SETTLE) ? cnt_r + 1'b1 : {`SOCC_CNT_W{1'b0}};
            // Bias stays up through the stop state so the last half cycle ends at dc
            bias_o <= (st_nxt != ST_OFF);
            toggle_o <= (st_nxt == ST_RUN);
        end
    end
    assign drive_p_o = bias_o;
    assign drive_n_o = bias_o && (fmt_i != `SOCC_FMT_LVCMOS);
endmodule

// file: rtl/socc_top.v
`timescale 1ns/1ps
`include "socc_regs.vh"
module socc_top (
    input wire clk_i,
    input wire rst_n_i,
    input wire [`SOCC_CTRL_W-1:0] otp_ctrl_i,
    input wire [31:0] otp_refb_i,
    input wire [15:0] otp_fmt_i,
    input wire wr_i,
    input wire rd_i,
    input wire [`SOCC_ADDR_W-1:0] addr_i,
    input wire [31:0] wdata_i,
    output reg [31:0] rdata_o,
    input wire [3:0] output_enable_pin_i,
    input wire pll1_powerdown_pin_i,
    input wire ref_out_enable_pin_i,
    output wire pll1_power_o,
    output wire pll2_power_o,
    output wire pll1_ref2_o,
    output wire pll2_ref2_o,
    output wire xtal_amp1_o,
    output wire xtal_amp2_o,
    output wire [4:0] bias_o,
    output wire [4:0] toggle_o,
    output wire [4:0] drive_p_o,
    output wire [4:0] drive_n_o,
    output wire [9:0] fmt_o,
    output wire buffered_reference_output_sel_o,
    output reg soft_reset_o
);
    reg [`SOCC_CTRL_W-1:0] ctrl_r;
    reg [31:0] refb_r;
    reg [15:0] fmt_r;
    reg loaded_r;
    reg [5:0] s1_r;
    reg [5:0] s2_r;
    reg [5:0] s3_r;
    reg [5:0] pin_r;
    wire [5:0] pin_raw;
    wire [4:0] eff_en;
    wire [3:0] ovr;
    wire [3:0] outbit;
    wire [`SOCC_CTRL_W-1:0] ctrl_rd;
    wire pll1_pw;
    wire pll2_pw;
    wire soft_go;

    function sel_ref2;
        input en;
        input sel;
        begin
            sel_ref2 = en & sel;
        end
    endfunction

    // Three-stage filter: level taken only once stages two and three agree
    assign pin_raw = {ref_out_enable_pin_i, pll1_powerdown_pin_i, output_enable_pin_i};
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_r <= 6'h3f;
            s2_r <= 6'h3f;
            s3_r <= 6'h3f;
            pin_r <= 6'h3f;
        end
        else
        begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
        end
    end

    assign soft_go = wr_i && (addr_i == `SOCC_REG_CTRL) && wdata_i[`SOCC_B_SR_EN] && wdata_i[`SOCC_B_SR];

    // Defaults come in after reset release, never under the asynchronous reset
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            loaded_r <= 1'b0;
            ctrl_r <= {`SOCC_CTRL_W{1'b0}};
            refb_r <= 32'h0;
            fmt_r <= 16'h0;
            soft_reset_o <= 1'b0;
        end
        else
        begin
            loaded_r <= 1'b1;
            soft_reset_o <= soft_go;
            if (!loaded_r || soft_go)
            begin
                ctrl_r <= otp_ctrl_i;
                refb_r <= otp_refb_i;
                fmt_r <= otp_fmt_i;
            end
            else if (wr_i)
            begin
                case (addr_i)
                    `SOCC_REG_CTRL: ctrl_r <= (ctrl_r & ~`SOCC_CTRL_RW_MASK) |
                                              (wdata_i[`SOCC_CTRL_W-1:0] & `SOCC_CTRL_RW_MASK);
                    `SOCC_REG_REFB: refb_r <= wdata_i;
                    `SOCC_REG_FMT: fmt_r <= wdata_i[15:0];
                    default: ;
                endcase
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_out
            assign ovr[g] = ctrl_r[`SOCC_B_OUT_BASE + 2*g];
        end
    endgenerate

    // Driver enable bits: writable only when override set in the written value
    reg [3:0] outbit_r;
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            outbit_r <= 4'h0;
        else if (!loaded_r || soft_go)
            outbit_r <= {otp_ctrl_i[15], otp_ctrl_i[13], otp_ctrl_i[11], otp_ctrl_i[9]};
        else if (wr_i && addr_i == `SOCC_REG_CTRL)
            outbit_r <= ({wdata_i[15], wdata_i[13], wdata_i[11], wdata_i[9]} &
                         {wdata_i[14], wdata_i[12], wdata_i[10], wdata_i[8]}) |
                        (outbit_r & ~{wdata_i[14], wdata_i[12], wdata_i[10], wdata_i[8]});
    end
    assign outbit = outbit_r;

    assign pll1_pw = ctrl_r[`SOCC_B_PLL1_EN] ? ctrl_r[`SOCC_B_PLL1] : pin_r[4];
    assign pll2_pw = ctrl_r[`SOCC_B_PLL2];
    assign pll1_power_o = pll1_pw;
    assign pll2_power_o = pll2_pw;
    assign pll1_ref2_o = sel_ref2(ctrl_r[`SOCC_B_RS1_EN], ctrl_r[`SOCC_B_RS1]);
    assign pll2_ref2_o = sel_ref2(ctrl_r[`SOCC_B_RS2_EN], ctrl_r[`SOCC_B_RS2]);
    assign buffered_reference_output_sel_o = refb_r[`SOCC_B_REFO_MUX];
    // A powered-down PLL does not hold its amplifier on
    assign xtal_amp1_o = refb_r[`SOCC_B_XTAL1] | (pll1_pw & ~pll1_ref2_o) |
                         (pll2_pw & ~pll2_ref2_o) | (eff_en[4] & ~refb_r[`SOCC_B_REFO_MUX]);
    assign xtal_amp2_o = fmt_r[`SOCC_B_XTAL2] | (pll1_pw & pll1_ref2_o) |
                         (pll2_pw & pll2_ref2_o) | (eff_en[4] & refb_r[`SOCC_B_REFO_MUX]);

    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_en
            // Outputs 1,2 sit on PLL1 and outputs 3,4 on PLL2
            assign eff_en[g] = (ovr[g] ? outbit[g] : pin_r[g]) & ((g < 2) ? pll1_pw : pll2_pw);
        end
    endgenerate
    assign eff_en[4] = ctrl_r[`SOCC_B_REFO_EN] ? ctrl_r[`SOCC_B_REFO] : pin_r[5];

    assign fmt_o = {refb_r[`SOCC_B_REFO_MODE+1:`SOCC_B_REFO_MODE], fmt_r[7:0]};

    generate
        for (g = 0; g < 5; g = g + 1)
        begin : g_seq
            socc_seq u_seq (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .en_i(eff_en[g]),
                .fmt_i(fmt_o[2*g+1:2*g]),
                .bias_o(bias_o[g]),
                .toggle_o(toggle_o[g]),
                .drive_p_o(drive_p_o[g]),
                .drive_n_o(drive_n_o[g])
            );
        end
    endgenerate

    assign ctrl_rd = {ctrl_r[23:16],
                      ovr[3] ? outbit[3] : pin_r[3], ctrl_r[14],
                      ovr[2] ? outbit[2] : pin_r[2], ctrl_r[12],
                      ovr[1] ? outbit[1] : pin_r[1], ctrl_r[10],
                      ovr[0] ? outbit[0] : pin_r[0], ctrl_r[8],
                      ctrl_r[7:0]};

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= 32'h0;
        else if (rd_i)
        begin
            case (addr_i)
                `SOCC_REG_CTRL: rdata_o <= {8'h0, ctrl_rd};
                `SOCC_REG_REFB: rdata_o <= refb_r;
                `SOCC_REG_FMT: rdata_o <= {16'h0, fmt_r};
                default: rdata_o <= 32'h0;
            endcase
        end
    end
endmodule

// file: tb/socc_pin_model.sv
`timescale 1ns/1ps
module socc_pin_model (
    input wire clk_i,
    input wire [3:0] oe_req_i,
    input wire pd_req_i,
    input wire ref_req_i,
    output logic [3:0] output_enable_pin_o,
    output logic pll1_powerdown_pin_o,
    output logic ref_out_enable_pin_o
);
    // Pins idle high, as the board pull-ups leave them
    initial {output_enable_pin_o, pll1_powerdown_pin_o, ref_out_enable_pin_o} = 6'h3f;
    always @(negedge clk_i)
    begin
        output_enable_pin_o <= oe_req_i;
        pll1_powerdown_pin_o <= pd_req_i;
        ref_out_enable_pin_o <= ref_req_i;
    end
endmodule

// file: tb/socc_top_sva.sv
`timescale 1ns/1ps
`include "socc_regs.vh"
module socc_top_sva (
    input wire clk_i,
    input wire rst_n_i,
    input wire wr_i,
    input wire [`SOCC_ADDR_W-1:0] addr_i,
    input wire [31:0] wdata_i,
    input wire pll1_power_o,
    input wire pll2_power_o,
    input wire pll1_ref2_o,
    input wire [4:0] bias_o,
    input wire [4:0] toggle_o,
    input wire [4:0] drive_n_o,
    input wire [9:0] fmt_o,
    input wire soft_reset_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Soft reset writes reload defaults, so they are kept out of the write checks
    sequence s_wr2;
        wr_i && addr_i == `SOCC_REG_CTRL && wdata_i[19:18] != 2'h3;
    endsequence
    sequence s_off1;
        !pll1_power_o [*3];
    endsequence
    property p_pll1; s_wr2 ##0 wdata_i[0] |=> pll1_power_o == $past(wdata_i[1]); endproperty
    property p_pll2; s_wr2 |=> pll2_power_o == $past(wdata_i[3]); endproperty
    property p_ref1; s_wr2 |=> pll1_ref2_o == $past(wdata_i[4] && wdata_i[5]); endproperty
    property p_gate1; s_off1 |-> bias_o[1:0] == 2'h0; endproperty
    property p_settle; $rose(toggle_o[0]) |-> $past(bias_o[0], 499); endproperty
    property p_order; $fell(toggle_o[0]) |=> !bias_o[0]; endproperty
    property p_fmt; wr_i && addr_i == `SOCC_REG_FMT |=> fmt_o[7:0] == $past(wdata_i[7:0]); endproperty
    property p_cmos; fmt_o[1:0] == `SOCC_FMT_LVCMOS |-> !drive_n_o[0]; endproperty
    property p_sreset; soft_reset_o |-> $past(wr_i && addr_i == `SOCC_REG_CTRL && wdata_i[19:18] == 2'h3); endproperty
    a_pll1: assert property (p_pll1) else $error("pll1 power differs from written bit");
    a_pll2: assert property (p_pll2) else $error("pll2 power differs from written bit");
    a_ref1: assert property (p_ref1) else $error("pll1 reference choice wrong");
    a_gate1: assert property (p_gate1) else $error("driver on while its pll is down");
    a_settle: assert property (p_settle) else $error("toggling began before settle time");
    a_order: assert property (p_order) else $error("bias kept after toggling stopped");
    a_fmt: assert property (p_fmt) else $error("format field not taken");
    a_cmos: assert property (p_cmos) else $error("negative pin driven in single-ended mode");
    a_sreset: assert property (p_sreset) else $error("soft reset without its enable");
endmodule
bind socc_top socc_top_sva i_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .pll1_power_o(pll1_power_o), .pll2_power_o(pll2_power_o), .pll1_ref2_o(pll1_ref2_o),
    .bias_o(bias_o), .toggle_o(toggle_o), .drive_n_o(drive_n_o), .fmt_o(fmt_o), .soft_reset_o(soft_reset_o));

// file: tb/socc_top_tb_top.sv
`timescale 1ns/1ps
`include "socc_regs.vh"
module socc_top_tb_top;
    logic clk_i = 0;
    logic rst_n_i = 0;
    logic wr_i = 0;
    logic rd_i = 0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic [31:0] rdata_o;
    logic [31:0] d;
    logic [3:0] oe_q = 4'hf;
    logic pd_q = 1;
    logic ro_q = 1;
    logic seen;
    wire [3:0] oe_w;
    wire pd_w;
    wire ro_w;
    wire p1, p2, r1, r2, a1, a2, rs, sr;
    wire [4:0] bias, tog, dp, dn;
    wire [9:0] fmt;
    int fails = 0;
    int n_compared = 0;
    int n;
    socc_pin_model i_pins (.clk_i(clk_i), .oe_req_i(oe_q), .pd_req_i(pd_q), .ref_req_i(ro_q),
        .output_enable_pin_o(oe_w), .pll1_powerdown_pin_o(pd_w), .ref_out_enable_pin_o(ro_w));
    socc_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .otp_ctrl_i(24'h000100), .otp_refb_i(32'h0),
        .otp_fmt_i(16'h0), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .output_enable_pin_i(oe_w), .pll1_powerdown_pin_i(pd_w), .ref_out_enable_pin_i(ro_w),
        .pll1_power_o(p1), .pll2_power_o(p2), .pll1_ref2_o(r1), .pll2_ref2_o(r2), .xtal_amp1_o(a1),
        .xtal_amp2_o(a2), .bias_o(bias), .toggle_o(tog), .drive_p_o(dp), .drive_n_o(dn), .fmt_o(fmt),
        .buffered_reference_output_sel_o(rs), .soft_reset_o(sr));
    task automatic results;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(negedge clk_i);
        wr_i = 1;
        addr_i = a;
        wdata_i = v;
        @(negedge clk_i);
        wr_i = 0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(negedge clk_i);
        rd_i = 1;
        addr_i = a;
        @(negedge clk_i);
        rd_i = 0;
        d = rdata_o;
    endtask
    task automatic srw(input logic [31:0] v, input logic e);
        wr(`SOCC_REG_CTRL, v);
        seen = 0;
        repeat (3)
        begin
            seen = seen | sr;
            @(negedge clk_i);
        end
        chk("soft_reset", seen, e);
    endtask
    initial forever #2 clk_i = ~clk_i;
    initial
    begin
        cyc(10);
        rst_n_i = 1;
        cyc(3);
        chk("fmt", fmt, 0);
        chk("pll1", p1, 1);
        chk("pll2", p2, 0);
        cyc(6);
        chk("bias", bias[1:0], 2'h2);
        rd(`SOCC_REG_CTRL);
        chk("reg2", d[15:0], 16'ha900);
        pd_q = 0;
        cyc(6);
        chk("pll1", p1, 0);
        cyc(3);
        chk("bias", bias[1:0], 0);
        wr(`SOCC_REG_CTRL, 32'h10f);
        cyc(1);
        chk("pll", {p1, p2}, 2'h3);
        oe_q = 4'hd;
        cyc(6);
        rd(`SOCC_REG_CTRL);
        chk("reg2", d[15:8], 8'ha1);
        wr(`SOCC_REG_CTRL, 32'h90f);
        rd(`SOCC_REG_CTRL);
        chk("reg2", d[15:8], 8'ha1);
        wr(`SOCC_REG_CTRL, 32'h30f);
        cyc(1);
        chk("bias", bias[0], 1);
        n = 0;
        while (tog[0] !== 1'b1 && n < 600)
        begin
            @(negedge clk_i);
            n++;
        end
        chk("settle", n, `SOCC_SETTLE_CYC);
        if (n == 600)
            results;
        for (int f = 0; f < 4; f++)
        begin
            wr(`SOCC_REG_FMT, {24'h0, {4{f[1:0]}}});
            cyc(1);
            chk("fmt", fmt[7:0], {4{f[1:0]}});
            chk("drive_n", dn[0], f != 0);
        end
        wr(`SOCC_REG_CTRL, 32'h30d);
        cyc(3);
        chk("out1", {bias[0], tog[0]}, 0);
        wr(`SOCC_REG_CTRL, 32'h177);
        cyc(1);
        chk("ref", {r1, r2, a2}, 3'h5);
        wr(`SOCC_REG_CTRL, 32'h1f5);
        cyc(1);
        chk("ref", {r1, r2, a2}, 3'h6);
        wr(`SOCC_REG_FMT, 32'h8000);
        cyc(1);
        chk("xtal2", a2, 1);
        ro_q = 0;
        cyc(10);
        chk("buffered_reference_output", bias[4], 0);
        chk("xtal1", a1, 0);
        wr(`SOCC_REG_REFB, 32'hcc000000);
        cyc(1);
        chk("xtal1", a1, 1);
        chk("refsel", rs, 1);
        chk("fmt4", fmt[9:8], 2'h3);
        rd(`SOCC_REG_REFB);
        chk("reg3", d, 32'hcc000000);
        wr(`SOCC_REG_CTRL, 32'h301f5);
        cyc(2);
        chk("buffered_reference_output", bias[4], 1);
        chk("refpins", {dp[4], dn[4]}, 2'h3);
        srw(32'h801f5, 0);
        srw(32'hc01f5, 1);
        cyc(2);
        chk("reload", {a1, rs, p2, fmt}, 0);
        rd(4'h7);
        chk("unmapped", d, 0);
        results;
    end
endmodule
